/* File: rtl/aimc_top.v */
// Converter front end control: enable, bias, input multiplexer, gain and result format.
// Functional notes
// - Converter, track-and-hold and amplifier are powered only while enable is 1.
// - Enable at 0 holds the whole converter subsystem in low power shutdown.
// - Twelve-bit successive-approximation converter with track-and-hold, up to 100ksps.
// - Nine sources: eight external inputs plus the internal temperature sensor.
// - Programmed gain applies to the temperature sensor like any external channel.
// - Each external input pair is single-ended or differential, independently.
// - Pair configuration may change any time; new setting used from then on.
// - Reset makes every input pair single-ended.
// - Multiplexer is controlled by channel select and pair configuration registers.
// - Gain comes from the three-bit gain field of the configuration register.
// - Gain field offers 0.5, 1, 2, 4, 8 and 16.
// - Reset loads the gain code for unity gain.
// - Pair bit 0 means single-ended; 1 joins even positive, odd negative.
// - Four-bit address: 0 to 7 external or its pair; 1xxx temperature sensor.
// - Differential results are delivered in two's complement.
//
// Added by the designer: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "aimc_defs.vh"

module aimc_top (
  // Clock and reset
  input  wire        mclk,
  input  wire        rstn,
  // AXI4-Lite write address
  input  wire [7:0]  awaddr,
  input  wire [2:0]  awprot,
  input  wire        awvalid,
  output reg         awready,
  // AXI4-Lite write data
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output reg         wready,
  // AXI4-Lite write response
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  // AXI4-Lite read address
  input  wire [7:0]  araddr,
  input  wire [2:0]  arprot,
  input  wire        arvalid,
  output reg         arready,
  // AXI4-Lite read data
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready,
  // Converter pins
  input  wire [11:0] sar_code,
  input  wire        sar_done,
  // Analog controls
  output reg         subsys_power,
  output reg         subsys_shutdown,
  output reg         bias_enable,
  output reg         sample_tick,
  output reg  [3:0]  mux_pos_sel,
  output reg  [2:0]  mux_neg_sel,
  output reg         mux_diff,
  output reg  [5:0]  gain_onehot
);

  // Reset release.
  reg        rst_s1;
  reg        rst_n;

  // Registers.
  reg        subsystem_enable_bit;
  reg        bias_enable_bit;
  reg  [3:0] channel_address_field;
  reg  [3:0] pair_config_register;
  reg  [2:0] gain_select_field;
  reg [11:0] result;
  reg        result_twos;

  // Bus state.
  reg        aw_hold;
  reg        w_hold;
  reg  [7:0] wr_addr;
  reg [31:0] wr_data;
  reg        wr_lane0;

  // Pin synchronisers.
  reg        done_s1;
  reg        done_s2;
  reg        done_s3;
  reg [11:0] code_s1;
  reg [11:0] code_s2;

  // Rate divider.
  reg  [6:0] rate_cnt;

  // Decoded source.
  wire [3:0] dec_pos;
  wire [2:0] dec_neg;
  wire       dec_diff;
  wire       dec_temp;
  reg  [5:0] next_gain_onehot;
  reg  [2:0] gain_index;
  reg [31:0] next_rdata;
  reg        rd_hit;
  reg        wr_hit;

  localparam integer CONV_LAST_I = `AIMC_CONV_CYC - 1;
  localparam [6:0]   CONV_LAST   = CONV_LAST_I[6:0];

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  aimc_src_decode u_dec (
    .chan_addr (channel_address_field),
    .pair_diff (pair_config_register),
    .pos_sel   (dec_pos),
    .neg_sel   (dec_neg),
    .diff      (dec_diff),
    .temp      (dec_temp)
  );

  always @* begin
    case (gain_select_field)
      `AIMC_GAIN_X1: begin
        next_gain_onehot = `AIMC_OH_X1;
        gain_index       = 3'h1;
      end
      `AIMC_GAIN_X2: begin
        next_gain_onehot = `AIMC_OH_X2;
        gain_index       = 3'h2;
      end
      `AIMC_GAIN_X4: begin
        next_gain_onehot = `AIMC_OH_X4;
        gain_index       = 3'h3;
      end
      `AIMC_GAIN_X8: begin
        next_gain_onehot = `AIMC_OH_X8;
        gain_index       = 3'h4;
      end
      `AIMC_GAIN_X16, `AIMC_GAIN_RSV16: begin
        next_gain_onehot = `AIMC_OH_X16;
        gain_index       = 3'h5;
      end
      default: begin
        next_gain_onehot = `AIMC_OH_HALF;
        gain_index       = 3'h0;
      end
    endcase
  end

  // Register read mux; reserved bits read zero.
  always @* begin
    next_rdata = 32'h0000_0000;
    rd_hit     = 1'b1;
    case (araddr)
      `AIMC_OFS_CTRL:    next_rdata[`AIMC_CTRL_EN_BIT] = subsystem_enable_bit;
      `AIMC_OFS_REF:     next_rdata[`AIMC_REF_BIAS_BIT] = bias_enable_bit;
      `AIMC_OFS_CHSEL:   next_rdata[3:0] = channel_address_field;
      `AIMC_OFS_PAIRCFG: next_rdata[3:0] = pair_config_register;
      `AIMC_OFS_CONVCFG: next_rdata[2:0] = gain_select_field;
      `AIMC_OFS_STATUS: begin
        next_rdata[0]     = subsystem_enable_bit;
        next_rdata[1]     = bias_enable_bit;
        next_rdata[2]     = subsystem_enable_bit & bias_enable_bit;
        next_rdata[3]     = dec_diff;
        next_rdata[4]     = dec_temp;
        next_rdata[8:5]   = dec_pos;
        next_rdata[11:9]  = dec_neg;
        next_rdata[14:12] = gain_index;
      end
      `AIMC_OFS_RESULT: begin
        next_rdata[11:0] = result;
        next_rdata[12]   = result_twos;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  always @* begin
    case (wr_addr)
      `AIMC_OFS_CTRL, `AIMC_OFS_REF, `AIMC_OFS_CHSEL,
      `AIMC_OFS_PAIRCFG, `AIMC_OFS_CONVCFG: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Write channels: address and data are latched separately, in either order.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      awready  <= 1'b0;
      wready   <= 1'b0;
      aw_hold  <= 1'b0;
      w_hold   <= 1'b0;
      wr_addr  <= 8'h00;
      wr_data  <= 32'h0000_0000;
      wr_lane0 <= 1'b0;
      bvalid   <= 1'b0;
      bresp    <= `AIMC_RESP_OKAY;
    end else begin
      awready <= awvalid & ~awready & ~aw_hold & ~bvalid;
      wready  <= wvalid & ~wready & ~w_hold & ~bvalid;
      if (awvalid && awready) begin
        aw_hold <= 1'b1;
        wr_addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_hold   <= 1'b1;
        wr_data  <= wdata;
        wr_lane0 <= wstrb[0];
      end
      if (aw_hold && w_hold && !bvalid) begin
        aw_hold <= 1'b0;
        w_hold  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= wr_hit ? `AIMC_RESP_OKAY : `AIMC_RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Register writes. Nothing gates them on enable so software can set up while shut down.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      subsystem_enable_bit  <= `AIMC_RST_EN;
      bias_enable_bit       <= `AIMC_RST_BIAS;
      channel_address_field <= `AIMC_RST_CHSEL;
      pair_config_register  <= `AIMC_RST_PAIR;
      gain_select_field     <= `AIMC_RST_GAIN;
    end else if (aw_hold && w_hold && !bvalid && wr_lane0) begin
      case (wr_addr)
        `AIMC_OFS_CTRL:    subsystem_enable_bit <= wr_data[`AIMC_CTRL_EN_BIT];
        `AIMC_OFS_REF:     bias_enable_bit <= wr_data[`AIMC_REF_BIAS_BIT];
        `AIMC_OFS_CHSEL:   channel_address_field <= wr_data[3:0];
        `AIMC_OFS_PAIRCFG: pair_config_register <= wr_data[3:0];
        `AIMC_OFS_CONVCFG: gain_select_field <= wr_data[2:0];
        default: ;
      endcase
    end
  end

  // Read channel.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= `AIMC_RESP_OKAY;
    end else begin
      arready <= arvalid & ~arready & ~rvalid;
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata  <= next_rdata;
        rresp  <= rd_hit ? `AIMC_RESP_OKAY : `AIMC_RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // Converter pins come from the analog macro's own timing, so both pass two flip-flops.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      done_s1 <= 1'b0;
      done_s2 <= 1'b0;
      done_s3 <= 1'b0;
      code_s1 <= 12'h000;
      code_s2 <= 12'h000;
    end else begin
      done_s1 <= sar_done;
      done_s2 <= done_s1;
      done_s3 <= done_s2;
      code_s1 <= sar_code;
      code_s2 <= code_s1;
    end
  end

  // The code must be steady before done rises; code and done pass the same two stages, with no extra cycles of margin.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      result      <= 12'h000;
      result_twos <= 1'b0;
    end else if (done_s2 && !done_s3 && subsystem_enable_bit) begin
      result_twos <= mux_diff;
      if (mux_diff) begin
        result <= {~code_s2[11], code_s2[10:0]};
      end else begin
        result <= code_s2;
      end
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rate_cnt    <= 7'h00;
      sample_tick <= 1'b0;
    end else if (!(subsystem_enable_bit && bias_enable_bit)) begin
      rate_cnt    <= 7'h00;
      sample_tick <= 1'b0;
    end else if (rate_cnt == CONV_LAST) begin
      rate_cnt    <= 7'h00;
      sample_tick <= 1'b1;
    end else begin
      rate_cnt    <= rate_cnt + 7'h01;
      sample_tick <= 1'b0;
    end
  end

  // Analog control outputs, all registered.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      subsys_power    <= 1'b0;
      subsys_shutdown <= 1'b1;
      bias_enable     <= 1'b0;
      mux_pos_sel     <= 4'h0;
      mux_neg_sel     <= 3'h0;
      mux_diff        <= 1'b0;
      gain_onehot     <= `AIMC_OH_X1;
    end else begin
      subsys_power    <= subsystem_enable_bit;
      subsys_shutdown <= ~subsystem_enable_bit;
      bias_enable     <= bias_enable_bit;
      mux_pos_sel     <= dec_pos;
      mux_neg_sel     <= dec_neg;
      mux_diff        <= dec_diff;
      gain_onehot     <= next_gain_onehot;
    end
  end

endmodule
`default_nettype wire

/* File: rtl/aimc_defs.vh */
// Register map, field positions, reset values and timing counts of the converter front end.
`ifndef AIMC_DEFS_VH
`define AIMC_DEFS_VH

// Register byte offsets on the AXI4-Lite bus.
`define AIMC_OFS_CTRL      8'h00
`define AIMC_OFS_REF       8'h04
`define AIMC_OFS_CHSEL     8'h08
`define AIMC_OFS_PAIRCFG   8'h0C
`define AIMC_OFS_CONVCFG   8'h10
`define AIMC_OFS_STATUS    8'h14
`define AIMC_OFS_RESULT    8'h18

// Field positions.
`define AIMC_CTRL_EN_BIT   7
`define AIMC_REF_BIAS_BIT  1
`define AIMC_CHSEL_W       4
`define AIMC_PAIR_W        4
`define AIMC_GAIN_W        3

// Reset values.
`define AIMC_RST_EN        1'h0
`define AIMC_RST_BIAS      1'h0
`define AIMC_RST_CHSEL     4'h0
`define AIMC_RST_PAIR      4'h0
`define AIMC_RST_GAIN      3'h0

// Gain codes; 3'h5 and 3'h7 are reserved aliases.
`define AIMC_GAIN_X1       3'h0
`define AIMC_GAIN_X2       3'h1
`define AIMC_GAIN_X4       3'h2
`define AIMC_GAIN_X8       3'h3
`define AIMC_GAIN_X16      3'h4
`define AIMC_GAIN_RSV16    3'h5
`define AIMC_GAIN_XHALF    3'h6
`define AIMC_GAIN_RSVHALF  3'h7

// One-hot gain outputs, bit order 0.5, 1, 2, 4, 8, 16.
`define AIMC_OH_HALF       6'h01
`define AIMC_OH_X1         6'h02
`define AIMC_OH_X2         6'h04
`define AIMC_OH_X4         6'h08
`define AIMC_OH_X8         6'h10
`define AIMC_OH_X16        6'h20

// Source code of the temperature sensor on the positive select.
`define AIMC_SRC_TEMP      4'h8

// Converter figures and timing.
`define AIMC_RES_BITS      12
`define AIMC_RATE_KSPS     100
`define AIMC_MCLK_KHZ      10000
`define AIMC_CONV_CYC      (`AIMC_MCLK_KHZ / `AIMC_RATE_KSPS)
`define AIMC_CNT_W         7

// Bus answers.
`define AIMC_RESP_OKAY     2'h0
`define AIMC_RESP_SLVERR   2'h2

`endif

/* File: rtl/aimc_src_decode.v */
// Channel address and pair configuration decode into multiplexer selects.
`timescale 1ns/100ps
`default_nettype none
`include "aimc_defs.vh"

module aimc_src_decode (
  // Settings
  input  wire [3:0] chan_addr,
  input  wire [3:0] pair_diff,
  // Decoded source
  output reg  [3:0] pos_sel,
  output reg  [2:0] neg_sel,
  output reg        diff,
  output reg        temp
);

  always @* begin
    pos_sel = {1'b0, chan_addr[2:0]};
    neg_sel = 3'h0;
    diff    = 1'b0;
    temp    = 1'b0;
    if (chan_addr[3]) begin
      pos_sel = `AIMC_SRC_TEMP;
      temp    = 1'b1;
    end else if (pair_diff[chan_addr[2:1]]) begin
      pos_sel = {1'b0, chan_addr[2:1], 1'b0};
      neg_sel = {chan_addr[2:1], 1'b1};
      diff    = 1'b1;
    end
  end

endmodule
`default_nettype wire

/* File: tb/aimc_top_assertions.sv */
// Concurrent checks on the converter front end control ports.
`timescale 1ns/100ps
`default_nettype none
`include "aimc_defs.vh"
module aimc_chk (
  // Clock, reset and read channel
  input wire logic       mclk,
  input wire logic       rstn,
  input wire logic       arvalid,
  input wire logic       arready,
  input wire logic       rvalid,
  input wire logic       rready,
  input wire logic [1:0] rresp,
  // Analog controls
  input wire logic       subsys_power,
  input wire logic       subsys_shutdown,
  input wire logic       bias_enable,
  input wire logic       sample_tick,
  input wire logic [3:0] mux_pos_sel,
  input wire logic [2:0] mux_neg_sel,
  input wire logic       mux_diff,
  input wire logic [5:0] gain_onehot
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  property p_pwr; subsys_power != subsys_shutdown; endproperty
  a_pwr: assert property (p_pwr) else $error("power and shutdown agree");
  property p_tick; sample_tick |-> subsys_power && bias_enable; endproperty
  a_tick: assert property (p_tick) else $error("tick without power or bias");
  property p_gap; sample_tick |=> !sample_tick [*8]; endproperty
  a_gap: assert property (p_gap) else $error("ticks too close");
  property p_temp; mux_pos_sel[3] |-> mux_pos_sel == `AIMC_SRC_TEMP && !mux_diff; endproperty
  a_temp: assert property (p_temp) else $error("bad sensor select");
  property p_diff;
    mux_diff |-> !mux_pos_sel[0] && !mux_pos_sel[3] && mux_neg_sel == mux_pos_sel[2:0] + 3'h1;
  endproperty
  a_diff: assert property (p_diff) else $error("bad differential pair");
  property p_se; !mux_diff |-> mux_neg_sel == 3'h0; endproperty
  a_se: assert property (p_se) else $error("negative select in single-ended");
  property p_gain; $onehot(gain_onehot); endproperty
  a_gain: assert property (p_gain) else $error("gain not one-hot");
  property p_rst;
    $rose(rstn) |-> gain_onehot == `AIMC_OH_X1 && !mux_diff && subsys_shutdown;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset defaults");
  property p_rd; arvalid && arready |=> rvalid; endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
  property p_rhold; rvalid && !rready |=> rvalid && $stable(rresp); endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
  c_tick: cover property (sample_tick);
  c_diff: cover property (mux_diff);
  c_temp: cover property (mux_pos_sel == `AIMC_SRC_TEMP);
  c_err: cover property (rvalid && rresp == `AIMC_RESP_SLVERR);
endmodule
bind aimc_top aimc_chk u_aimc_chk (
  .mclk, .rstn, .arvalid, .arready, .rvalid, .rready, .rresp, .subsys_power,
  .subsys_shutdown, .bias_enable, .sample_tick, .mux_pos_sel, .mux_neg_sel, .mux_diff,
  .gain_onehot
);
`default_nettype wire

/* File: tb/adc_input_mux_gain_control_tb.sv */
// Self-checking testbench for the converter front end control block.
`timescale 1ns/100ps
`default_nettype none
`include "aimc_defs.vh"
module adc_input_mux_gain_control_tb;
  logic        mclk, rstn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, sar_done, mux_diff;
  logic        subsys_power, subsys_shutdown, bias_enable, sample_tick;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [11:0] sar_code;
  logic [3:0]  mux_pos_sel;
  logic [2:0]  mux_neg_sel;
  logic [5:0]  gain_onehot;
  int          fail_count, checks;
  aimc_top u_aimc_top (
    .mclk, .rstn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb(4'hF),
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .sar_code, .sar_done, .subsys_power,
    .subsys_shutdown, .bias_enable, .sample_tick, .mux_pos_sel, .mux_neg_sel, .mux_diff,
    .gain_onehot
  );
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // A wait that runs out ends the run rather than hanging it.
  task automatic tmo(input int n);
    if (n >= 300) begin
      fail_count++;
      summarize();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 300 && !bvalid; n++) begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    tmo(n);
    chk(bresp, er);
    bready <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 300 && !rvalid; n++) begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
    end
    tmo(n);
    chk(rdata, ed);
    chk(rresp, er);
    rready <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic conv(input logic [11:0] code);
    sar_code <= code;
    repeat (2) @(posedge mclk);
    sar_done <= 1'b1;
    repeat (3) @(posedge mclk);
    sar_done <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask
  task automatic s_reset;
    chk(gain_onehot, `AIMC_OH_X1);
    chk({subsys_power, subsys_shutdown, mux_diff}, 3'b010);
    rd(`AIMC_OFS_PAIRCFG, 32'h0, `AIMC_RESP_OKAY);
    rd(`AIMC_OFS_CONVCFG, 32'h0, `AIMC_RESP_OKAY);
  endtask
  task automatic s_bus;
    rd(8'h1C, 32'h0, `AIMC_RESP_SLVERR);
    wr(8'h1C, 32'h5, `AIMC_RESP_SLVERR);
    wr(`AIMC_OFS_STATUS, 32'h5, `AIMC_RESP_SLVERR);
    wr(`AIMC_OFS_CHSEL, 32'hFF, `AIMC_RESP_OKAY);
    rd(`AIMC_OFS_CHSEL, 32'h0F, `AIMC_RESP_OKAY);
  endtask
  // Every pair mask against every address, all while the subsystem is shut down.
  task automatic s_mux;
    logic [3:0] p, c, ep;
    logic       d;
    for (int i = 0; i < 16; i++) begin
      p = i[3:0];
      wr(`AIMC_OFS_PAIRCFG, {28'h0, p}, `AIMC_RESP_OKAY);
      for (int j = 0; j < 16; j++) begin
        c = j[3:0];
        wr(`AIMC_OFS_CHSEL, {28'h0, c}, `AIMC_RESP_OKAY);
        d = !c[3] && p[c[2:1]];
        ep = c[3] ? `AIMC_SRC_TEMP : (d ? {1'b0, c[2:1], 1'b0} : c);
        chk({mux_pos_sel, mux_neg_sel, mux_diff}, {ep, d ? {c[2:1], 1'b1} : 3'h0, d});
      end
    end
    chk(subsys_shutdown, 1'b1);
    rd(`AIMC_OFS_PAIRCFG, 32'hF, `AIMC_RESP_OKAY);
  endtask
  task automatic s_gain;
    logic [5:0] gt [8];
    gt = '{`AIMC_OH_X1, `AIMC_OH_X2, `AIMC_OH_X4, `AIMC_OH_X8, `AIMC_OH_X16,
      `AIMC_OH_X16, `AIMC_OH_HALF, `AIMC_OH_HALF};
    wr(`AIMC_OFS_CHSEL, {28'h0, `AIMC_SRC_TEMP}, `AIMC_RESP_OKAY);
    for (int i = 0; i < 16; i++) begin
      wr(`AIMC_OFS_CONVCFG, i % 8, `AIMC_RESP_OKAY);
      chk(gain_onehot, gt[i % 8]);
    end
  endtask
  task automatic s_tick;
    int n;
    int k;
    wr(`AIMC_OFS_REF, 32'h1 << `AIMC_REF_BIAS_BIT, `AIMC_RESP_OKAY);
    wr(`AIMC_OFS_CTRL, 32'h1 << `AIMC_CTRL_EN_BIT, `AIMC_RESP_OKAY);
    chk({subsys_power, subsys_shutdown, bias_enable}, 3'b101);
    for (n = 0; n < 300 && !sample_tick; n++)
      @(posedge mclk);
    tmo(n);
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (!sample_tick && n < 300);
    chk(n, `AIMC_CONV_CYC);
    wr(`AIMC_OFS_REF, 32'h0, `AIMC_RESP_OKAY);
    k = 0;
    repeat (300) begin
      @(posedge mclk);
      k += sample_tick;
    end
    chk(k, 0);
  endtask
  task automatic s_result;
    wr(`AIMC_OFS_PAIRCFG, 32'h1, `AIMC_RESP_OKAY);
    wr(`AIMC_OFS_CHSEL, 32'h1, `AIMC_RESP_OKAY);
    conv(12'h123);
    rd(`AIMC_OFS_RESULT, 32'h1923, `AIMC_RESP_OKAY);
    rd(`AIMC_OFS_STATUS, 32'h209, `AIMC_RESP_OKAY);
    wr(`AIMC_OFS_PAIRCFG, 32'h0, `AIMC_RESP_OKAY);
    conv(12'h456);
    rd(`AIMC_OFS_RESULT, 32'h0456, `AIMC_RESP_OKAY);
    wr(`AIMC_OFS_CTRL, 32'h0, `AIMC_RESP_OKAY);
    chk({subsys_power, subsys_shutdown}, 2'b01);
    conv(12'hABC);
    rd(`AIMC_OFS_RESULT, 32'h0456, `AIMC_RESP_OKAY);
  endtask
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    fail_count = 0;
    checks = 0;
    rstn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, sar_done} = '0;
    {awaddr, araddr, wdata, sar_code} = '0;
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    repeat (3) @(posedge mclk);
    s_reset();
    s_bus();
    s_mux();
    s_gain();
    s_tick();
    s_result();
    summarize();
  end
endmodule
`default_nettype wire
